// ### hdl/bcl_bus_control.sv
// Bus control: cycle start, lock, multi-cycle lock and hold arbitration.
//
// Contract
// - While the lock pin is asserted a bus hold is refused, address hold still honoured.
// - Lock asserts in the first clock of the first locked cycle and drops after the final one ends.
// - Lock, multi-cycle lock and cycle start are active low and undriven during bus hold.
// - A locked read is never turned into a cache line fill.
// - Multi-cycle lock stays active until the address of the final cycle has been driven.
// - Multi-cycle lock covers 64-bit float and descriptor accesses and 128-bit line fills.
// - Multi-cycle lock and final transfer are both inactive while idle, then complementary, except both active in 64-bit write first cycle.
// - Multi-cycle lock depends on the cacheable input, not on the byte size and half size inputs.
// - The cycle start strobe is asserted in the clock the address is driven.
// - Non-burst ready ends the current cycle.
// - Ready is ignored while idle and at the end of a cycle's first clock.
// - Ready still completes cycles while address hold is asserted.
`timescale 1ns/1ps
`default_nettype none

module bcl_bus_control (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Core request side.
  input wire bcl_pkg::bcl_req_t req,
  input wire logic reqValid,
  output logic reqReady,
  output logic cycleDone,
  output logic lineFill,
  // System inputs.
  input wire logic ready_n,
  input wire logic cacheable_n,
  input wire logic size_byte_n,
  input wire logic size_half_n,
  input wire logic holdReq,
  input wire logic address_hold_req,
  // System outputs.
  output bcl_pkg::bcl_pins_t pins,
  output logic holdAck,
  output logic addrEnable
);

  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_WAIT, ST_HOLD} bcl_state_t;

  bcl_state_t state;
  bcl_pkg::bcl_req_t cur;
  logic [2:0] remaining;
  logic cycleLockOn;
  logic firstWrite;
  logic loadCnt;
  logic [2:0] loadVal;
  logic readyTaken;
  logic moreCycles;

  // Width of the transaction in extra 32-bit cycles.
  function automatic logic [2:0] extraCycles(bcl_pkg::bcl_kind_t k,
      logic locked, logic cache_n, logic b8_n, logic b16_n);
    logic [2:0] n;
    n = bcl_pkg::BCL_CNT_ZERO;
    if (k == bcl_pkg::BCL_FP_READ64 || k == bcl_pkg::BCL_FP_WRITE64 ||
        k == bcl_pkg::BCL_DESC_READ64) begin
      n = bcl_pkg::BCL_CNT_QWORD;
    end
    // A locked read never grows into a line fill.
    if (!locked && !cache_n && k != bcl_pkg::BCL_FP_WRITE64) begin
      n = bcl_pkg::BCL_CNT_LINE;
    end
    // Narrow ports only split the word; they do not add locked cycles here.
    if ((!b8_n || !b16_n) && n == bcl_pkg::BCL_CNT_ZERO) begin
      n = bcl_pkg::BCL_CNT_ZERO;
    end
    return n;
  endfunction

  // Ready is only seen after the first clock of a cycle.
  assign readyTaken = (state == ST_WAIT) && !ready_n;
  assign moreCycles = remaining != bcl_pkg::BCL_CNT_ZERO;
  assign loadVal = extraCycles(cur.kind, cur.locked, cacheable_n,
      size_byte_n, size_half_n);
  assign loadCnt = (state == ST_FIRST) && (cur.kind != bcl_pkg::BCL_SINGLE
      || !cacheable_n) && !firstWrite;

  bcl_count u_count (
    .clk(clk),
    .resetn(resetn),
    .load(loadCnt),
    .loadValue(loadVal),
    .step(readyTaken),
    .remaining(remaining)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Hold is refused while a lock sequence is open.
          if (holdReq && !cycleLockOn) begin
            state <= ST_HOLD;
          end else if (reqValid) begin
            state <= ST_FIRST;
          end
        end
        ST_FIRST: state <= ST_WAIT;
        ST_WAIT: begin
          if (readyTaken) begin
            state <= moreCycles ? ST_FIRST : ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!holdReq) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur <= '0;
      firstWrite <= 1'b0;
    end else if (state == ST_IDLE && !(holdReq && !cycleLockOn) && reqValid) begin
      cur <= req;
      firstWrite <= 1'b0;
    end else if (state == ST_WAIT && readyTaken && moreCycles) begin
      cur.addr <= cur.addr + {28'h0, bcl_pkg::BCL_ADDR_STEP};
      firstWrite <= 1'b1;
    end
  end

  // Lock stays on from the first locked cycle until ready ends the last one.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cycleLockOn <= 1'b0;
    end else if (state == ST_IDLE && reqValid && req.locked &&
                 !(holdReq && !cycleLockOn)) begin
      cycleLockOn <= 1'b1;
    end else if (readyTaken && !moreCycles && cur.lastLocked) begin
      cycleLockOn <= 1'b0;
    end
  end

  logic nextFirst;
  logic lastAddr;
  assign nextFirst = (state == ST_IDLE && reqValid && !(holdReq && !cycleLockOn))
      || (state == ST_WAIT && readyTaken && moreCycles);
  // Final address is the one driven when no further cycle remains.
  assign lastAddr = (state == ST_WAIT && readyTaken && remaining == 3'h1);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pins.cycleStartStrobe_n <= 1'b1;
      pins.cycleLock_n <= 1'b1;
      pins.multiCycleLock_n <= 1'b1;
      pins.finalTransfer_n <= 1'b1;
      pins.addr <= '0;
      pins.pinEnable <= 1'b1;
      holdAck <= 1'b0;
      addrEnable <= 1'b1;
    end else begin
      pins.cycleStartStrobe_n <= !nextFirst;
      // The address holds for the whole cycle, not only its first clock.
      if (nextFirst) begin
        pins.addr <= (state == ST_IDLE) ? req.addr
            : cur.addr + {28'h0, bcl_pkg::BCL_ADDR_STEP};
      end
      // Lock drops at the edge that ends the last locked cycle.
      pins.cycleLock_n <= !((cycleLockOn &&
          !(readyTaken && !moreCycles && cur.lastLocked)) ||
          (state == ST_IDLE && reqValid && req.locked &&
          !(holdReq && !cycleLockOn)));
      if (state == ST_FIRST && !firstWrite) begin
        // Both active only in the first cycle of a 64-bit write.
        pins.multiCycleLock_n <= !(loadVal != bcl_pkg::BCL_CNT_ZERO);
        pins.finalTransfer_n <= (cur.kind == bcl_pkg::BCL_FP_WRITE64 &&
            !firstWrite) ? 1'b0 : (loadVal != bcl_pkg::BCL_CNT_ZERO);
      end else if (state == ST_FIRST) begin
        // Follow-on cycles take their lock from the cycles still owed.
        pins.multiCycleLock_n <= !moreCycles;
        pins.finalTransfer_n <= moreCycles;
      end else if (lastAddr) begin
        pins.multiCycleLock_n <= 1'b1;
        pins.finalTransfer_n <= 1'b0;
      end else if (state == ST_IDLE) begin
        pins.multiCycleLock_n <= 1'b1;
        pins.finalTransfer_n <= 1'b1;
      end
      pins.pinEnable <= !(state == ST_HOLD ||
          (state == ST_IDLE && holdReq && !cycleLockOn));
      holdAck <= (state == ST_IDLE && holdReq && !cycleLockOn)
          || (state == ST_HOLD && holdReq);
      addrEnable <= !address_hold_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reqReady <= 1'b0;
      cycleDone <= 1'b0;
      lineFill <= 1'b0;
    end else begin
      reqReady <= state == ST_IDLE && reqValid && !(holdReq && !cycleLockOn);
      cycleDone <= readyTaken;
      lineFill <= loadCnt && loadVal == bcl_pkg::BCL_CNT_LINE;
    end
  end

  // Assertions.
  property p_hold_refused;
    @(posedge clk) disable iff (!resetn)
      cycleLockOn |-> ##1 !holdAck || $past(holdAck);
  endproperty
  a_hold_refused: assert property (p_hold_refused)
    else $error("Hold granted while locked.");

  property p_float_in_hold;
    @(posedge clk) disable iff (!resetn)
      holdAck |-> !pins.pinEnable;
  endproperty
  a_float_in_hold: assert property (p_float_in_hold)
    else $error("Pins driven during hold.");

  property p_no_locked_fill;
    @(posedge clk) disable iff (!resetn)
      (state == ST_FIRST && cur.locked) |-> loadVal != bcl_pkg::BCL_CNT_LINE;
  endproperty
  a_no_locked_fill: assert property (p_no_locked_fill)
    else $error("Locked read became a line fill.");

  property p_idle_ready;
    @(posedge clk) disable iff (!resetn)
      (state != ST_WAIT && !ready_n) |=> !cycleDone;
  endproperty
  a_idle_ready: assert property (p_idle_ready)
    else $error("Ready taken outside wait.");

  property p_strobe;
    @(posedge clk) disable iff (!resetn)
      !pins.cycleStartStrobe_n |-> state == ST_FIRST;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("Strobe without a started cycle.");

  property p_lock_drop;
    @(posedge clk) disable iff (!resetn)
      (readyTaken && !moreCycles && cur.lastLocked) |=>
          !cycleLockOn && pins.cycleLock_n;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("Lock held after last locked cycle.");

  property p_done;
    @(posedge clk) disable iff (!resetn)
      readyTaken |=> cycleDone;
  endproperty
  a_done: assert property (p_done)
    else $error("Ready did not complete the cycle.");

  property p_first_ignored;
    @(posedge clk) disable iff (!resetn)
      state == ST_FIRST |=> state == ST_WAIT;
  endproperty
  a_first_ignored: assert property (p_first_ignored)
    else $error("Cycle ended at first clock.");

  c_line: cover property (@(posedge clk) disable iff (!resetn) lineFill);
  c_hold: cover property (@(posedge clk) disable iff (!resetn) holdAck);
  c_lock: cover property (@(posedge clk) disable iff (!resetn)
      !pins.cycleLock_n ##1 pins.cycleLock_n);

endmodule
`default_nettype wire

// ### hdl/bcl_count.sv
// Cycle counter: how many 32-bit bus cycles remain after the current one.
`timescale 1ns/1ps
`default_nettype none

module bcl_count (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Control.
  input wire logic load,
  input wire logic [2:0] loadValue,
  input wire logic step,
  // State.
  output logic [2:0] remaining
);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      remaining <= bcl_pkg::BCL_CNT_ZERO;
    end else if (load) begin
      remaining <= loadValue;
    end else if (step && remaining != bcl_pkg::BCL_CNT_ZERO) begin
      remaining <= remaining - 3'h1;
    end
  end

endmodule
`default_nettype wire

// ### hdl/bcl_pkg.sv
// Package for the bus lock and cycle control block.
`default_nettype none
package bcl_pkg;

  // Transaction kinds requested by the core.
  typedef enum logic [2:0] {
    BCL_SINGLE,
    BCL_FP_READ64,
    BCL_FP_WRITE64,
    BCL_DESC_READ64,
    BCL_CODE_READ
  } bcl_kind_t;

  // One transaction request from the core side.
  typedef struct packed {
    bcl_kind_t kind;
    logic locked;
    logic lastLocked;
    logic isRead;
    logic [31:0] addr;
  } bcl_req_t;

  // The pin group: active-low strobe and locks, address, and one output enable.
  typedef struct packed {
    logic cycleStartStrobe_n;
    logic cycleLock_n;
    logic multiCycleLock_n;
    logic finalTransfer_n;
    logic [31:0] addr;
    logic pinEnable;
  } bcl_pins_t;

  localparam logic [2:0] BCL_CNT_QWORD = 3'h1;
  localparam logic [2:0] BCL_CNT_LINE = 3'h3;
  localparam logic [3:0] BCL_ADDR_STEP = 4'h4;
  localparam logic [2:0] BCL_CNT_ZERO = 3'h0;

endpackage
`default_nettype wire

// ### verif/bcl_mem_model.sv
// Memory controller model that ends each bus cycle with non-burst ready.
`timescale 1ns/1ps
`default_nettype none

module bcl_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Bus pins and answer settings.
  input wire bcl_pkg::bcl_pins_t pins,
  input wire logic [3:0] waitStates,
  input wire logic early,
  // Answer.
  output logic ready_n
);
  logic [4:0] cnt;
  logic readyQ;
  logic start;

  assign start = pins.pinEnable && !pins.cycleStartStrobe_n;
  // A ready in the first clock is offered on purpose; it must not count.
  assign ready_n = readyQ && !(early && start);

  // The all-ones count means no cycle is waiting for an answer.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= 5'h1f;
      readyQ <= 1'b1;
    end else if (start) begin
      cnt <= {1'b0, waitStates} - 5'h1;
      readyQ <= !(waitStates == 4'h0);
    end else begin
      // Ready is answered whether or not address hold is on.
      readyQ <= (cnt != 5'h0);
      if (cnt != 5'h1f) begin
        cnt <= cnt - 5'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/tb_bcl_bus_control.sv
// Testbench for the bus lock and cycle control block.
`timescale 1ns/1ps
`default_nettype none

module tb_bcl_bus_control;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reqValid = 1'b0;
  logic cacheable_n = 1'b1;
  logic size_byte_n = 1'b1;
  logic size_half_n = 1'b1;
  logic holdReq = 1'b0;
  logic address_hold_req = 1'b0;
  logic early = 1'b0;
  logic [3:0] waitStates = 4'h0;
  bcl_pkg::bcl_req_t req = '0;
  logic reqReady, cycleDone, lineFill, ready_n, holdAck, addrEnable;
  bcl_pkg::bcl_pins_t pins;
  int errors = 0;
  int n_compared = 0;

  bcl_bus_control dut (.clk, .resetn, .req, .reqValid, .reqReady,
    .cycleDone, .lineFill, .ready_n, .cacheable_n, .size_byte_n,
    .size_half_n, .holdReq, .address_hold_req, .pins, .holdAck,
    .addrEnable);
  bcl_mem_model mem (.clk, .resetn, .pins, .waitStates, .early, .ready_n);

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One transaction; every cycle is checked as it passes.
  task automatic xfer(input bcl_pkg::bcl_kind_t kind, input logic lk,
      input logic lastLk, input logic cache, input int ws, input int nCyc,
      input logic expFill, input logic ah);
    int t = 0;
    int k = 0;
    int n = 0;
    logic fill = 1'b0;
    req = '{kind, lk, lastLk, kind != bcl_pkg::BCL_FP_WRITE64, 32'h1000};
    cacheable_n = !cache;
    waitStates = ws[3:0];
    reqValid = 1'b1;
    for (int g = 0; g < 300 && n < nCyc; g++) begin
      @(posedge clk);
      #1;
      t++;
      if (reqReady === 1'b1) reqValid = 1'b0;
      if (lineFill === 1'b1) fill = 1'b1;
      if (pins.cycleLock_n === 1'b0) chk(holdAck, 0);
      if (address_hold_req && t > 0) chk(addrEnable, 0);
      if (cycleDone === 1'b1) begin
        chk(t, 2 + ws);
        n++;
      end
      if (pins.cycleStartStrobe_n === 1'b0) begin
        chk(pins.addr, 32'h1000 + 4 * k);
        chk(pins.cycleLock_n, !lk);
        chk(reqReady, k == 0);
        if (ah) address_hold_req = 1'b1;
        t = 0;
        k++;
      end
      if (ready_n === 1'b0 && t > 0) begin
        chk(pins.addr, 32'h1000 + 4 * (k - 1));
        chk(pins.multiCycleLock_n, k == nCyc);
        chk(pins.finalTransfer_n,
          (kind == bcl_pkg::BCL_FP_WRITE64 && k == 1) ? 0 : k != nCyc);
      end
    end
    address_hold_req = 1'b0;
    cacheable_n = 1'b1;
    chk(n, nCyc);
    chk(fill, expFill);
    repeat (2) @(posedge clk);
    #1;
    chk(pins.cycleLock_n, !(lk && !lastLk));
  endtask

  // Narrow size inputs are moved too; the cycle count must not change.
  task automatic t_multi();
    early = 1'b1;
    xfer(bcl_pkg::BCL_SINGLE, 0, 0, 0, 0, 1, 0, 0);
    size_byte_n = 1'b0;
    xfer(bcl_pkg::BCL_FP_READ64, 0, 0, 0, 1, 2, 0, 0);
    size_byte_n = 1'b1;
    xfer(bcl_pkg::BCL_FP_WRITE64, 0, 0, 0, 0, 2, 0, 0);
    size_half_n = 1'b0;
    xfer(bcl_pkg::BCL_DESC_READ64, 0, 0, 0, 2, 2, 0, 0);
    size_half_n = 1'b1;
    xfer(bcl_pkg::BCL_CODE_READ, 0, 0, 1, 0, 4, 1, 0);
    xfer(bcl_pkg::BCL_CODE_READ, 0, 0, 0, 1, 1, 0, 0);
    early = 1'b0;
  endtask

  // Hold is asked for while the lock is open and only granted afterwards.
  task automatic t_lock_hold();
    xfer(bcl_pkg::BCL_CODE_READ, 1, 0, 1, 0, 1, 0, 0);
    holdReq = 1'b1;
    xfer(bcl_pkg::BCL_SINGLE, 1, 1, 0, 1, 1, 0, 0);
    for (int g = 0; g < 20 && holdAck !== 1'b1; g++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    chk({holdAck, pins.pinEnable}, 2'h2);
    holdReq = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({holdAck, pins.pinEnable}, 2'h1);
  endtask

  task automatic t_address_hold_req();
    xfer(bcl_pkg::BCL_SINGLE, 0, 0, 0, 2, 1, 0, 1);
  endtask

  initial begin
    #20000;
    errors++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    chk({pins.cycleStartStrobe_n, pins.cycleLock_n, pins.multiCycleLock_n,
      pins.pinEnable, holdAck, addrEnable}, 6'h3d);
    resetn = 1'b1;
    t_multi();
    t_lock_hold();
    t_address_hold_req();
    conclude();
  end
endmodule

`default_nettype wire
